// >>> rtl/bst_pkg.sv
// ============================================================
// Shared constants and types of the boundary-scan test port.
package bst_pkg;

  // Length of the boundary-scan chain, cells 0 through 168.
  localparam int BSR_LEN = 169;

  // Instruction codes held in the two-bit instruction register.
  localparam logic [1:0] IR_EXTEST = 2'h0;
  localparam logic [1:0] IR_BYPASS = 2'h3;
  // Value loaded at capture-IR, and the value after a test reset.
  localparam logic [1:0] IR_CAPTURE = 2'h1;
  localparam logic [1:0] IR_RESET = 2'h3;
  localparam logic BYP_CAPTURE = 1'h0;

  // Test port input pins, sampled together by the system clock.
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } bst_pins_s;

  // Serial data output pin with its output enable.
  typedef struct packed {
    logic tdo;
    logic oe;
  } bst_tdo_s;

  // Test-access controller states, one-hot.
  typedef enum logic [15:0] {
    ST_RESET = 16'h0001,
    ST_IDLE = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PAU_DR = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PAU_IR = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } bst_state_e;

endpackage : bst_pkg

// >>> rtl/bst_test_port.sv
// Notes on behaviour
// - Mode select is sampled at each test clock rise and steps the controller.
// - Mode select and data input read one when undriven, by pad pull-ups.
// - Data input is sampled at clock rise into instruction or selected data register.
// - Data output changes only at test clock falling edges.
// - Data output is high impedance whenever no register is being shifted.
// - Test reset clears the scan logic; undriven it is pulled inactive high.
// - Instruction register is two bits, loading serially only in shift-IR.
// - Code 00 is EXTEST, 11 is BYPASS, 01 and 10 are SAMPLE/PRELOAD.
// - The instruction selects the data register and the serial path.
// - Exactly two data registers exist: boundary chain and bypass.
// - Bypass is one stage, a single-bit delay from input to output.
// - Boundary cell 0 is the first bit shifted out.
// - Three-state control cells enable their driver when holding one.
// - Test clock is independent; scanning never disturbs the switch logic.
// - The boundary chain holds cells 0 through 168 in fixed order.
`timescale 1ns/1ps
`default_nettype none

module bst_test_port #(
  parameter int CHAIN_LEN = bst_pkg::BSR_LEN
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire bst_pkg::bst_pins_s pins,
  input wire logic [CHAIN_LEN-1:0] capt_data,
  output logic [CHAIN_LEN-1:0] upd_data,
  output logic extest_mode,
  output bst_pkg::bst_tdo_s tdo_pin
);
  import bst_pkg::*;

  // ============================================================
  // Pin synchroniser and test clock edge detection.
  // The test clock is foreign to clk, so every pin passes two flops
  // and only the second stage is examined. Pull-ups sit in the pads,
  // so an undriven pin already arrives here as one.
  bst_pins_s sync1_r;
  bst_pins_s sync2_r;
  logic tck_prev_r;
  wire tck_rise = sync2_r.tck & ~tck_prev_r;
  wire tck_fall = ~sync2_r.tck & tck_prev_r;
  wire tms_s = sync2_r.tms;
  wire tdi_s = sync2_r.tdi;
  wire trst_s_n = sync2_r.trst_n;

  always_ff @(posedge clk)
  begin
    sync1_r <= pins;
    sync2_r <= sync1_r;
    tck_prev_r <= sync2_r.tck;
  end

  // ============================================================
  // Test-access controller.
  bst_state_e state_r;
  bst_state_e state_nxt;

  // Standard sixteen-state transition table on the sampled mode select.
  always_comb
  begin
    unique case (state_r)
      ST_RESET: state_nxt = tms_s ? ST_RESET : ST_IDLE;
      ST_IDLE: state_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_nxt = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_nxt = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: state_nxt = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_nxt = tms_s ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: state_nxt = tms_s ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: state_nxt = tms_s ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: state_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_nxt = tms_s ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: state_nxt = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: state_nxt = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_nxt = tms_s ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: state_nxt = tms_s ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: state_nxt = tms_s ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: state_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
      default: state_nxt = ST_RESET;
    endcase
  end

  // The controller only moves on a test clock rise; the test reset
  // overrides everything.
  always_ff @(posedge clk)
  begin
    if (!reset_n || !trst_s_n)
      state_r <= ST_RESET;
    else if (tck_rise)
      state_r <= state_nxt;
  end

  // ============================================================
  // Instruction register and decode.
  logic [1:0] ir_sh_r;
  logic [1:0] ir_r;
  wire sel_bypass = (ir_r == IR_BYPASS);
  wire sel_extest = (ir_r == IR_EXTEST);
  wire sh_ir = (state_r == ST_SH_IR);
  wire sh_dr = (state_r == ST_SH_DR);

  // Shift toward bit 0, which leaves first; shifts only in shift-IR, takes 01 in capture-IR.
  always_ff @(posedge clk)
  begin
    if (!reset_n || !trst_s_n || (tck_rise && state_r == ST_RESET))
    begin
      ir_sh_r <= IR_RESET;
      ir_r <= IR_RESET;
    end
    else if (tck_rise)
    begin
      if (state_r == ST_CAP_IR)
        ir_sh_r <= IR_CAPTURE;
      else if (sh_ir)
        ir_sh_r <= {tdi_s, ir_sh_r[1]};
      if (state_r == ST_UPD_IR)
        ir_r <= ir_sh_r;
    end
  end

  // ============================================================
  // Data registers: boundary chain and one-stage bypass.
  // The chain captures whatever the cells see at the pins, so under
  // SAMPLE/PRELOAD the core keeps the pins while they are recorded.
  logic [CHAIN_LEN-1:0] bsr_r;
  logic [CHAIN_LEN-1:0] upd_r;
  logic byp_r;

  always_ff @(posedge clk)
  begin
    if (!reset_n || !trst_s_n)
    begin
      bsr_r <= '0;
      upd_r <= '0;
      byp_r <= BYP_CAPTURE;
    end
    else if (tck_rise)
    begin
      if (state_r == ST_CAP_DR)
      begin
        byp_r <= BYP_CAPTURE;
        if (!sel_bypass)
          bsr_r <= capt_data;
      end
      else if (sh_dr)
      begin
        if (sel_bypass)
          byp_r <= tdi_s;
        else
          bsr_r <= {tdi_s, bsr_r[CHAIN_LEN-1:1]};
      end
      if (state_r == ST_UPD_DR && !sel_bypass)
        upd_r <= bsr_r;
    end
  end

  // Update cells drive the pins only under EXTEST; a control cell
  // holding one enables its driver, so no inversion is applied.
  assign upd_data = upd_r;
  assign extest_mode = sel_extest;

  // ============================================================
  // Serial output, retimed to the test clock falling edge so the
  // tester can sample it safely at the next rise.
  bst_tdo_s tdo_r;
  wire tdo_bit = sh_ir ? ir_sh_r[0] : (sel_bypass ? byp_r : bsr_r[0]);

  always_ff @(posedge clk)
  begin
    if (!reset_n || !trst_s_n)
      tdo_r <= '0;
    else if (tck_fall)
    begin
      tdo_r.tdo <= tdo_bit;
      tdo_r.oe <= sh_ir | sh_dr;
    end
  end

  assign tdo_pin = tdo_r;

  // ============================================================
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_dr_shift;
    tck_rise && sh_dr && !sel_bypass;
  endsequence

  sequence s_byp_shift;
    tck_rise && sh_dr && sel_bypass;
  endsequence

  a_state_on_rise: assert property (!tck_rise && trst_s_n |=> $stable(state_r))
    else $error("Controller moved without a test clock rise.");
  a_tdo_fall_only: assert property ($changed(tdo_r) && $past(reset_n) && $past(trst_s_n)
    |-> $past(tck_fall))
    else $error("Serial output changed away from a falling edge.");
  a_tdo_hiz_idle: assert property (tck_fall && !sh_ir && !sh_dr |=> !tdo_r.oe)
    else $error("Serial output driven while nothing shifts.");
  a_trst_clears: assert property (!trst_s_n |=> state_r == ST_RESET && ir_r == IR_RESET)
    else $error("Test reset did not clear the controller.");
  a_ir_shift_in: assert property (tck_rise && sh_ir && trst_s_n |=>
    ir_sh_r[1] == $past(tdi_s) && ir_sh_r[0] == $past(ir_sh_r[1]))
    else $error("Instruction shift lost a bit.");
  // The decode is judged against the code that was shifted in, not against
  // the decode wires themselves, so a wrong compare value would show.
  a_extest_decode: assert property (tck_rise && state_r == ST_UPD_IR && trst_s_n |=>
    extest_mode == ($past(ir_sh_r) == 2'h0) && sel_bypass == ($past(ir_sh_r) == 2'h3))
    else $error("EXTEST decode wrong.");
  a_bypass_delay: assert property (s_byp_shift ##0 trst_s_n |=> byp_r == $past(tdi_s))
    else $error("Bypass stage did not take the input bit.");
  a_bsr_cell0_out: assert property (tck_fall && sh_dr && !sel_bypass && trst_s_n |=>
    tdo_r.tdo == $past(bsr_r[0]) && tdo_r.oe)
    else $error("Cell 0 did not appear first on the output.");
  a_bsr_shift_in: assert property (s_dr_shift ##0 trst_s_n |=>
    bsr_r[CHAIN_LEN-1] == $past(tdi_s) && bsr_r[0] == $past(bsr_r[1]))
    else $error("Chain shift did not move one cell toward cell 0.");
  a_update_copy: assert property (tck_rise && state_r == ST_UPD_DR &&
    !sel_bypass && trst_s_n |=> upd_data == $past(bsr_r))
    else $error("Update cells did not take the chain contents.");
  a_capture_pins: assert property (tck_rise && state_r == ST_CAP_DR &&
    !sel_bypass && trst_s_n |=> bsr_r == $past(capt_data))
    else $error("Chain did not capture the pin values.");

endmodule : bst_test_port

`default_nettype wire

// >>> verif/bst_tester.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Far-side test controller that drives the test port pins.
module bst_tester (
  input wire logic clk,
  input wire bst_pkg::bst_tdo_s tdo_pin,
  output var bst_pkg::bst_pins_s pins
);
  import bst_pkg::*;

  // Idle pins rest at their pull-up level while the test clock stands low.
  initial pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};

  // One 320 ns test clock period, 3 clk high and 5 clk low.
  // The output is read late in the low phase, after the port's answer has settled.
  task automatic step(input logic tms, input logic tdi, output bst_tdo_s seen);
    @(posedge clk);
    pins.tck <= 1'b1;
    pins.tms <= tms;
    pins.tdi <= tdi;
    repeat (3) @(posedge clk);
    pins.tck <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    // A released output shows the inverse of its level, so a read outside a shift fails.
    seen.oe = tdo_pin.oe;
    seen.tdo = tdo_pin.oe ? tdo_pin.tdo : ~tdo_pin.tdo;
  endtask : step

  // Test reset pulse, held long enough to pass the synchroniser.
  task automatic treset();
    @(posedge clk);
    pins.trst_n <= 1'b0;
    repeat (4) @(posedge clk);
    pins.trst_n <= 1'b1;
  endtask : treset
endmodule : bst_tester

`default_nettype wire

// >>> verif/tb_boundary_scan_test_port.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Self-checking bench of the boundary-scan test port.
module tb_boundary_scan_test_port;
  import bst_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  bst_pins_s pins;
  bst_tdo_s tdo_pin;
  bst_tdo_s s;
  logic extest_mode;
  logic [BSR_LEN-1:0] upd_data;
  logic [BSR_LEN-1:0] cap = {5'h15, {41{4'h9}}};
  logic [BSR_LEN-1:0] capt_data = {5'h15, {41{4'h9}}};
  int num_errors = 0;
  int n_compared = 0;

  // The 25 MHz system clock.
  always #20 clk = ~clk;

  bst_test_port #(.CHAIN_LEN(BSR_LEN)) u_dut (.clk(clk), .reset_n(reset_n), .pins(pins),
    .capt_data(capt_data), .upd_data(upd_data), .extest_mode(extest_mode), .tdo_pin(tdo_pin));
  bst_tester u_tst (.clk(clk), .tdo_pin(tdo_pin), .pins(pins));

  task automatic chk(input logic [BSR_LEN-1:0] got, input logic [BSR_LEN-1:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("mismatches %0d, compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // Instruction scan from idle back to idle, checking the captured value shifted out.
  task automatic ir(input logic [1:0] code);
    bst_tdo_s s0, s1, s2;
    u_tst.step(1'b1, 1'b1, s0);
    u_tst.step(1'b1, 1'b1, s0);
    u_tst.step(1'b0, 1'b1, s0);
    u_tst.step(1'b0, 1'b1, s0);
    u_tst.step(1'b0, code[0], s1);
    u_tst.step(1'b1, code[1], s2);
    chk({s0, s1}, 4'hd);
    chk(s2.oe, 1'b0);
    u_tst.step(1'b1, 1'b1, s0);
    u_tst.step(1'b0, 1'b1, s0);
    chk(extest_mode, code == IR_EXTEST);
  endtask : ir

  // Data scan of n bits from idle back to idle; bit 0 of dout is the first seen.
  task automatic dr(input int n, input logic [BSR_LEN-1:0] din, output logic [BSR_LEN-1:0] dout);
    bst_tdo_s t;
    dout = '0;
    u_tst.step(1'b1, 1'b1, t);
    u_tst.step(1'b0, 1'b1, t);
    u_tst.step(1'b0, 1'b1, t);
    dout[0] = t.tdo;
    for (int i = 0; i < n; i++)
    begin
      u_tst.step(i == n - 1, din[i], t);
      if (i < n - 1)
        dout[i + 1] = t.tdo;
    end
    chk(t.oe, 1'b0);
    u_tst.step(1'b1, 1'b1, t);
    u_tst.step(1'b0, 1'b1, t);
  endtask : dr

  // A short scan must show the captured zero, then the input one bit late.
  task automatic byp_check();
    logic [BSR_LEN-1:0] o;
    dr(3, 169'h5, o);
    chk(o[2:0], 3'h2);
  endtask : byp_check

  // Main sequence: every instruction code, then both ways of resetting the port.
  initial
  begin
    logic [BSR_LEN-1:0] o, d;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({extest_mode, tdo_pin.oe}, 2'h0);
    u_tst.step(1'b0, 1'b1, s);
    for (int c = 0; c < 4; c++)
    begin
      ir(c[1:0]);
      if (c == 3)
        byp_check();
      else
      begin
        d = ~cap ^ 169'(c);
        dr(BSR_LEN, d, o);
        chk(o, cap);
      end
      chk(upd_data, d);
    end
    ir(2'h0);
    u_tst.treset();
    @(negedge clk);
    chk(extest_mode, 1'b0);
    u_tst.step(1'b0, 1'b1, s);
    byp_check();
    ir(2'h0);
    repeat (5) u_tst.step(1'b1, 1'b1, s);
    chk(extest_mode, 1'b0);
    u_tst.step(1'b0, 1'b1, s);
    byp_check();
    conclude();
  end

  // Watchdog, well beyond the roughly 4800 cycles that the sequence needs.
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    conclude();
  end
endmodule : tb_boundary_scan_test_port

`default_nettype wire
